// File: cmf_bit_timer.sv
// Time-quantum prescaler and nominal bit timing with resynchronisation
`timescale 1ns/100ps
`default_nettype none
module cmf_bit_timer (
  input  wire logic       clk_sys,
  input  wire logic       rst,
  input  wire logic [5:0] quantumPrescaler,
  input  wire logic [2:0] propSeg,
  input  wire logic [2:0] phaseBufferOne,
  input  wire logic [2:0] phaseBufferTwo,
  input  wire logic [1:0] jumpWidth,
  input  wire logic       busIn,
  input  wire logic       hardSync,
  output var  logic       tqTick,
  output var  logic       samplePoint,
  output var  logic       sampledBit,
  output var  logic       bitStart
);
  cmf_pkg::cmf_seg_t segQ;
  logic [5:0] preCntQ;
  logic [4:0] cntQ;
  logic [4:0] extQ;
  logic [4:0] shortQ;
  logic       syncDoneQ;
  logic       tqTickQ;
  logic       sampleQ;
  logic       bitQ;
  logic       startQ;

  // Effective prescaler clamped into 1..32 and segment lengths (field + 1)
  wire logic [5:0] brpEff = (quantumPrescaler < cmf_pkg::BRP_MIN) ? cmf_pkg::BRP_MIN :
                            (quantumPrescaler > cmf_pkg::BRP_MAX) ? cmf_pkg::BRP_MAX :
                            quantumPrescaler;
  wire logic [4:0] seg1Len = 5'(propSeg) + 5'(phaseBufferOne) + 5'h02;
  wire logic [4:0] ph2Len  = 5'(phaseBufferTwo) + 5'h01;
  wire logic [4:0] sjwLen  = 5'(jumpWidth) + 5'h01;
  wire logic       tqEn    = (preCntQ == brpEff - 6'h01);
  // Recessive at last sample, dominant now, one sync per sample interval
  wire logic       edgeSeen = tqEn && bitQ && !busIn && !syncDoneQ;
  wire logic [4:0] posErr   = cntQ + 5'h01;
  wire logic [4:0] negErr   = ph2Len - shortQ - cntQ;
  wire logic       seg1End  = (cntQ + 5'h01 >= seg1Len + extQ);
  wire logic       seg2End  = (cntQ + 5'h01 >= ph2Len - shortQ);

  // Prescaler divider
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      preCntQ <= 6'h00;
    else if (tqEn)
      preCntQ <= 6'h00;
    else
      preCntQ <= preCntQ + 6'h01;
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      segQ      <= cmf_pkg::SEG_SYNC;
      cntQ      <= 5'h00;
      extQ      <= 5'h00;
      shortQ    <= 5'h00;
      syncDoneQ <= 1'b0;
      sampleQ   <= 1'b0;
      bitQ      <= 1'b1;
      startQ    <= 1'b0;
    end
    else
    begin
      sampleQ <= 1'b0;
      startQ  <= 1'b0;
      if (tqEn)
      begin
        if (edgeSeen && (hardSync || segQ == cmf_pkg::SEG_SYNC))
        begin
          // Restart after the sync quantum, edge falls in sync
          segQ      <= cmf_pkg::SEG_ONE;
          cntQ      <= 5'h00;
          extQ      <= 5'h00;
          shortQ    <= 5'h00;
          syncDoneQ <= 1'b1;
          startQ    <= 1'b1;
        end
        else
        begin
          case (segQ)
            cmf_pkg::SEG_SYNC:
            begin
              segQ   <= cmf_pkg::SEG_ONE;
              cntQ   <= 5'h00;
              extQ   <= 5'h00;
              shortQ <= 5'h00;
            end
            cmf_pkg::SEG_ONE:
            begin
              if (edgeSeen)
              begin
                extQ      <= (posErr < sjwLen) ? posErr : sjwLen;
                syncDoneQ <= 1'b1;
              end
              if (seg1End && !edgeSeen)
              begin
                segQ      <= cmf_pkg::SEG_TWO;
                cntQ      <= 5'h00;
                sampleQ   <= 1'b1;
                bitQ      <= busIn;
                syncDoneQ <= 1'b0;
              end
              else
                cntQ <= cntQ + 5'h01;
            end
            default:
            begin
              if (edgeSeen && negErr <= sjwLen)
              begin
                segQ      <= cmf_pkg::SEG_ONE;
                cntQ      <= 5'h00;
                extQ      <= 5'h00;
                shortQ    <= 5'h00;
                syncDoneQ <= 1'b1;
                startQ    <= 1'b1;
              end
              else if (edgeSeen)
              begin
                shortQ    <= sjwLen;
                syncDoneQ <= 1'b1;
                cntQ      <= cntQ + 5'h01;
              end
              else if (seg2End)
              begin
                segQ   <= cmf_pkg::SEG_SYNC;
                cntQ   <= 5'h00;
                startQ <= 1'b1;
              end
              else
                cntQ <= cntQ + 5'h01;
            end
          endcase
        end
      end
    end
  end

  // Quantum strobe register
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      tqTickQ <= 1'b0;
    else
      tqTickQ <= tqEn;
  end

  assign tqTick      = tqTickQ;
  assign samplePoint = sampleQ;
  assign sampledBit  = bitQ;
  assign bitStart    = startQ;

  // Sample point only at quantum boundaries
  sampleOnTick_a: assert property (@(posedge clk_sys) disable iff (rst)
    sampleQ |-> tqTickQ)
    else $error("sample point away from a quantum boundary");
endmodule
`default_nettype wire

// File: cmf_msg_ctrl.sv
// Message object store, receive FIFO chaining, remote requests and interrupt identifier
`timescale 1ns/100ps
`default_nettype none
module cmf_msg_ctrl #(
  parameter int NUM_OBJ = cmf_pkg::MAX_OBJ
) (
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic        cmdStrobe,
  input  wire logic [7:0]  cmdMask,
  input  wire logic [5:0]  cmdObj,
  input  wire logic        bufValidIn,
  input  wire logic        bufDirIn,
  input  wire logic [28:0] bufIdIn,
  input  wire logic [15:0] bufCtrlIn,
  input  wire logic [63:0] bufDataIn,
  output var  logic        bufValid,
  output var  logic        bufDir,
  output var  logic [28:0] bufId,
  output var  logic [15:0] bufCtrl,
  output var  logic [63:0] bufData,
  input  wire logic        rxStore,
  input  wire logic [28:0] rxId,
  input  wire logic [3:0]  rxDlc,
  input  wire logic [63:0] rxData,
  output var  logic        remoteReq,
  output var  logic [5:0]  remoteObj,
  output var  logic [28:0] remoteId,
  input  wire logic        remoteSent,
  input  wire logic        coreStatusUpdate,
  input  wire logic        coreIsError,
  input  wire logic [4:0]  coreStatus,
  input  wire logic        swStatusWrite,
  input  wire logic [4:0]  swStatusData,
  input  wire logic        statusRead,
  output var  logic [4:0]  statusOut,
  input  wire logic        lineEnable,
  input  wire logic        errorIrqEnable,
  input  wire logic        statusIrqEnable,
  output var  logic [15:0] intId,
  output var  logic        irqLine,
  input  wire logic [5:0]  quantumPrescaler,
  input  wire logic [2:0]  propSeg,
  input  wire logic [2:0]  phaseBufferOne,
  input  wire logic [2:0]  phaseBufferTwo,
  input  wire logic [1:0]  jumpWidth,
  input  wire logic        busIn,
  input  wire logic        hardSync,
  output var  logic        tqTick,
  output var  logic        samplePoint,
  output var  logic        sampledBit,
  output var  logic        bitStart
);
  // Elaboration check on the object count
  if (NUM_OBJ < 1 || NUM_OBJ > cmf_pkg::MAX_OBJ)
  begin : gBadObjCount
    $error("NUM_OBJ must lie in 1..32");
  end

  // Per-object flags, held in flops
  logic [NUM_OBJ-1:0] freshQ, overrunQ, pendQ, sendReqQ, blockEndQ, rxIeQ, validQ, dirQ;
  logic [NUM_OBJ-1:0] freshD, overrunD, pendD, sendReqD, blockEndD, rxIeD, validD, dirD;
  logic [28:0] idMem   [NUM_OBJ];
  logic [63:0] dataMem [NUM_OBJ];
  logic [3:0]  dlcMem  [NUM_OBJ];
  logic        bufValidQ, bufDirQ, remoteReqQ, statusPendQ, irqLineQ;
  logic [28:0] bufIdQ, remoteIdQ;
  logic [15:0] bufCtrlQ, intIdQ;
  logic [63:0] bufDataQ;
  logic [5:0]  remoteObjQ;
  logic [4:0]  statusQ;

  // Command decode
  wire logic       cmdHit   = cmdStrobe && cmdObj != 6'h00 && cmdObj <= 6'(NUM_OBJ);
  wire logic [4:0] cmdIdx   = 5'(cmdObj - 6'h01);
  wire logic       cmdRead  = cmdHit && !cmdMask[cmf_pkg::MASK_WRITE];
  wire logic       cmdWrite = cmdHit && cmdMask[cmf_pkg::MASK_WRITE];

  // Receive match and FIFO member selection
  logic [31:0] rxMatch;
  always_comb
  begin
    rxMatch = 32'h0000_0000;
    for (int i = 0; i < NUM_OBJ; i++)
      rxMatch[i] = validQ[i] && !dirQ[i] && idMem[i] == rxId;
  end
  // locked members skipped by the store
  wire logic [31:0] lockMask = 32'(freshQ & ~blockEndQ);
  wire logic [31:0] rxCand   = rxMatch & ~lockMask;
  wire logic [5:0]  rxSel    = cmf_pkg::first_set(rxCand);
  wire logic        rxHit    = rxStore && rxSel[5];
  wire logic [4:0]  rxIdx    = rxSel[4:0];

  // Remote request and interrupt priority selection
  wire logic [5:0]  reqSel  = cmf_pkg::first_set(32'(sendReqQ & validQ & ~dirQ));
  wire logic [5:0]  pendSel = cmf_pkg::first_set(32'(pendQ));
  wire logic [15:0] intIdD  = statusPendQ ? cmf_pkg::INT_ID_STATUS :
                              pendSel[5] ? 16'(pendSel[4:0]) + 16'h0001 :
                              cmf_pkg::INT_ID_NONE;
  wire logic statusSet = coreStatusUpdate &&
                         ((coreIsError && errorIrqEnable) || (!coreIsError && statusIrqEnable));

  // Next flag values: software command first, receive store last so its sets win
  always_comb
  begin
    freshD = freshQ;
    overrunD = overrunQ;
    pendD = pendQ;
    sendReqD = sendReqQ;
    blockEndD = blockEndQ;
    rxIeD = rxIeQ;
    validD = validQ;
    dirD = dirQ;
    // read clears fresh and pending in RAM only
    if (cmdRead && cmdMask[cmf_pkg::MASK_REQ_FRESH])
      freshD[cmdIdx] = 1'b0;
    // clearing pending drops the object cause
    if (cmdRead && cmdMask[cmf_pkg::MASK_CLR_PEND])
      pendD[cmdIdx] = 1'b0;
    // remote sent drops the request; a same-cycle software set wins
    if (remoteSent && remoteReqQ)
      sendReqD[5'(remoteObjQ - 6'h01)] = 1'b0;
    if (cmdWrite && cmdMask[cmf_pkg::MASK_ARB])
    begin
      validD[cmdIdx] = bufValidIn;
      dirD[cmdIdx] = bufDirIn;
    end
    // overrun clears only by software write
    if (cmdWrite && cmdMask[cmf_pkg::MASK_CTRL])
    begin
      freshD[cmdIdx] = bufCtrlIn[cmf_pkg::MC_FRESH];
      overrunD[cmdIdx] = bufCtrlIn[cmf_pkg::MC_OVERRUN];
      pendD[cmdIdx] = bufCtrlIn[cmf_pkg::MC_PEND];
      rxIeD[cmdIdx] = bufCtrlIn[cmf_pkg::MC_RX_IE];
      sendReqD[cmdIdx] = bufCtrlIn[cmf_pkg::MC_SEND_REQ];
      blockEndD[cmdIdx] = bufCtrlIn[cmf_pkg::MC_BLOCK_END];
    end
    if (cmdWrite && cmdMask[cmf_pkg::MASK_REQ_FRESH])
      sendReqD[cmdIdx] = 1'b1;
    if (rxHit)
    begin
      // loss marked when fresh already set
      overrunD[rxIdx] = overrunD[rxIdx] | freshD[rxIdx];
      freshD[rxIdx] = 1'b1;
      pendD[rxIdx] = pendD[rxIdx] | rxIeD[rxIdx];
      sendReqD[rxIdx] = 1'b0;
    end
  end

  // Flag registers
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      {freshQ, overrunQ, pendQ, sendReqQ} <= '0;
      {blockEndQ, rxIeQ, validQ, dirQ} <= '0;
    end
    else
    begin
      {freshQ, overrunQ, pendQ, sendReqQ} <= {freshD, overrunD, pendD, sendReqD};
      {blockEndQ, rxIeQ, validQ, dirQ} <= {blockEndD, rxIeD, validD, dirD};
    end
  end

  // Object storage; a receive store overrides a same-cycle software write
  always_ff @(posedge clk_sys)
  begin
    if (cmdWrite && cmdMask[cmf_pkg::MASK_ARB])
      idMem[cmdIdx] <= bufIdIn;
    if (cmdWrite && cmdMask[cmf_pkg::MASK_CTRL])
      dlcMem[cmdIdx] <= bufCtrlIn[cmf_pkg::MC_DLC_MSB:0];
    if (cmdWrite && cmdMask[cmf_pkg::MASK_DATA_A])
      dataMem[cmdIdx][31:0] <= bufDataIn[31:0];
    if (cmdWrite && cmdMask[cmf_pkg::MASK_DATA_B])
      dataMem[cmdIdx][63:32] <= bufDataIn[63:32];
    // last member takes every overflow message
    if (rxHit)
    begin
      idMem[rxIdx] <= rxId;
      dlcMem[rxIdx] <= rxDlc;
      dataMem[rxIdx] <= rxData;
    end
  end

  // buffer holds control bits from before clearing
  wire logic [15:0] ctrlView = {freshQ[cmdIdx], overrunQ[cmdIdx], pendQ[cmdIdx], 2'b00,
                                rxIeQ[cmdIdx], 1'b0, sendReqQ[cmdIdx], blockEndQ[cmdIdx],
                                3'b000, dlcMem[cmdIdx]};

  // Interface buffer
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      bufValidQ <= 1'b0;
      bufDirQ <= 1'b0;
      bufIdQ <= cmf_pkg::ID_RESET;
      bufCtrlQ <= cmf_pkg::MC_RESET;
      bufDataQ <= cmf_pkg::DATA_RESET;
    end
    else if (cmdRead)
    begin
      bufValidQ <= validQ[cmdIdx];
      bufDirQ <= dirQ[cmdIdx];
      bufIdQ <= idMem[cmdIdx];
      bufCtrlQ <= ctrlView;
      bufDataQ <= dataMem[cmdIdx];
    end
  end

  // Remote request presentation
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      remoteReqQ <= 1'b0;
      remoteObjQ <= 6'h00;
      remoteIdQ <= cmf_pkg::ID_RESET;
    end
    else
    begin
      remoteReqQ <= reqSel[5];
      remoteObjQ <= reqSel[5] ? 6'(reqSel[4:0]) + 6'h01 : 6'h00;
      remoteIdQ <= idMem[reqSel[4:0]];
    end
  end

  // Status fields and status cause
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      statusQ <= cmf_pkg::STATUS_RESET;
      statusPendQ <= 1'b0;
    end
    else
    begin
      if (coreStatusUpdate)
        statusQ <= coreStatus;
      else if (swStatusWrite)
        statusQ <= swStatusData;
      // status read clears; a new update wins
      if (statusSet)
        statusPendQ <= 1'b1;
      else if (statusRead)
        statusPendQ <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      intIdQ <= cmf_pkg::INT_ID_NONE;
      irqLineQ <= 1'b0;
    end
    else
    begin
      intIdQ <= intIdD;
      irqLineQ <= lineEnable && intIdD != cmf_pkg::INT_ID_NONE;
    end
  end

  // Nominal bit timing
  cmf_bit_timer uTimer (
    .clk_sys          (clk_sys),
    .rst              (rst),
    .quantumPrescaler (quantumPrescaler),
    .propSeg          (propSeg),
    .phaseBufferOne   (phaseBufferOne),
    .phaseBufferTwo   (phaseBufferTwo),
    .jumpWidth        (jumpWidth),
    .busIn            (busIn),
    .hardSync         (hardSync),
    .tqTick           (tqTick),
    .samplePoint      (samplePoint),
    .sampledBit       (sampledBit),
    .bitStart         (bitStart)
  );

  // Output connections
  assign bufValid  = bufValidQ;
  assign bufDir    = bufDirQ;
  assign bufId     = bufIdQ;
  assign bufCtrl   = bufCtrlQ;
  assign bufData   = bufDataQ;
  assign remoteReq = remoteReqQ;
  assign remoteObj = remoteObjQ;
  assign remoteId  = remoteIdQ;
  assign statusOut = statusQ;
  assign intId     = intIdQ;
  assign irqLine   = irqLineQ;

  // Checks on the store, the buffer and the interrupt identifier
  fifoOrder_a: assert property (@(posedge clk_sys) disable iff (rst)
    rxHit |-> (rxCand & ((32'h0000_0001 << rxIdx) - 32'h0000_0001)) == 32'h0000_0000)
    else $error("store skipped a lower free member");
  storeFresh_a: assert property (@(posedge clk_sys) disable iff (rst)
    rxHit |=> freshQ[$past(rxIdx)] && !sendReqQ[$past(rxIdx)])
    else $error("store left fresh clear or request set");
  lossMark_a: assert property (@(posedge clk_sys) disable iff (rst)
    rxHit && freshQ[rxIdx] && !(cmdHit && cmdIdx == rxIdx) |=> overrunQ[$past(rxIdx)])
    else $error("overwrite of unread data not marked");
  overrunHold_a: assert property (@(posedge clk_sys) disable iff (rst)
    !(cmdWrite && cmdMask[cmf_pkg::MASK_CTRL]) |=> (overrunQ & $past(overrunQ)) == $past(overrunQ))
    else $error("overrun cleared without software");
  readClear_a: assert property (@(posedge clk_sys) disable iff (rst)
    cmdRead && cmdMask == cmf_pkg::CMD_READ_ALL && !rxStore
    |=> !freshQ[$past(cmdIdx)] && !pendQ[$past(cmdIdx)] &&
        bufCtrlQ[cmf_pkg::MC_FRESH] == $past(freshQ[cmdIdx]))
    else $error("read did not clear flags or lost old value");
  statusFirst_a: assert property (@(posedge clk_sys) disable iff (rst)
    statusPendQ |=> intIdQ == cmf_pkg::INT_ID_STATUS)
    else $error("status cause not reported first");
  lineFollow_a: assert property (@(posedge clk_sys) disable iff (rst)
    irqLineQ |-> intIdQ != cmf_pkg::INT_ID_NONE && $past(lineEnable))
    else $error("line active without cause or enable");
  swWriteQuiet_a: assert property (@(posedge clk_sys) disable iff (rst)
    swStatusWrite && !coreStatusUpdate && !statusRead |=> statusPendQ == $past(statusPendQ))
    else $error("status write changed the interrupt");
  objPrio_a: assert property (@(posedge clk_sys) disable iff (rst)
    !statusPendQ && pendSel[5] |=> $past(statusPendQ) || intIdQ == 16'($past(pendSel[4:0])) + 16'h0001)
    else $error("identifier not the lowest pending object");

  lastOverwrite_c: cover property (@(posedge clk_sys) disable iff (rst)
    rxHit && freshQ[rxIdx] && blockEndQ[rxIdx] && lockMask != 32'h0000_0000);
  statusIrq_c: cover property (@(posedge clk_sys) disable iff (rst)
    statusSet ##1 statusPendQ ##[1:20] statusRead);
  remoteSend_c: cover property (@(posedge clk_sys) disable iff (rst)
    remoteReqQ && remoteSent);
  readAll_c: cover property (@(posedge clk_sys) disable iff (rst)
    cmdRead && cmdMask == cmf_pkg::CMD_READ_ALL && pendQ[cmdIdx]);
endmodule
`default_nettype wire

// File: cmf_msg_ctrl_test.sv
// Self-checking bench for the message store, interrupt and bit-timing block
`timescale 1ns/100ps
`default_nettype none
module cmf_msg_ctrl_test;
  logic        clk_sys, rst, cmdStrobe, bufValidIn, bufDirIn, rxStore, remoteSent, busIn;
  logic        coreStatusUpdate, coreIsError, swStatusWrite, statusRead, lineEnable, hardSync;
  logic        errorIrqEnable, statusIrqEnable, bufValid, bufDir, remoteReq, irqLine;
  logic        tqTick, samplePoint, sampledBit, bitStart;
  logic [7:0]  cmdMask, lag;
  logic [5:0]  cmdObj, remoteObj, quantumPrescaler;
  logic [28:0] bufIdIn, bufId, rxId, remoteId;
  logic [15:0] bufCtrlIn, bufCtrl, intId;
  logic [63:0] bufDataIn, bufData, rxData;
  logic [4:0]  coreStatus, swStatusData, statusOut;
  logic [3:0]  rxDlc;
  logic [2:0]  propSeg, phaseBufferOne, phaseBufferTwo;
  logic [1:0]  jumpWidth;
  int          n_errors, cmp_count, i;
  `define CHK(nm, e, a) begin cmp_count++; if ((a) !== (e)) begin n_errors++; \
    $display("wrong value %s exp %0h got %0h", nm, e, a); end end
  cmf_msg_ctrl #(.NUM_OBJ(32)) dut_u (.*);
  cmf_remote_node far_u (.*);
  // Free-running system clock
  initial
  begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  task automatic stop_test();
    $display("checks %0d errors %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    cyc(1);
    s = 1'b0;
  endtask
  // Live view of a watched output: 0 remoteSent, 1 remoteReq, 2 bitStart
  function automatic logic probe(input int sel);
    return (sel == 0) ? remoteSent : (sel == 1) ? remoteReq : bitStart;
  endfunction
  // Bounded wait; i ends as the number of clocks waited
  task automatic waitv(input int sel, input logic v);
    for (i = 0; i < 300 && probe(sel) !== v; i++)
      cyc(1);
    if (probe(sel) !== v)
    begin
      n_errors++;
      stop_test();
    end
  endtask
  task automatic cmd(input logic [7:0] m, input logic [5:0] o);
    cmdMask = m;
    cmdObj = o;
    pulse(cmdStrobe);
    cyc(2);
  endtask
  task automatic wobj(input logic [5:0] o, input logic [28:0] id, input logic [15:0] c);
    bufIdIn = id;
    bufCtrlIn = c;
    cmd(8'hb0, o);
  endtask
  task automatic rx(input logic [63:0] d);
    rxData = d;
    pulse(rxStore);
    // Idle cycle so back-to-back stores never rewrite the strobe in one step
    cyc(1);
  endtask
  // FIFO fill, overwrite, ordered reads
  task automatic t_fifo();
    // equal identifiers, block end on last
    wobj(6'h01, 29'h123, 16'h0400);
    wobj(6'h02, 29'h123, 16'h0480);
    rxId = 29'h123;
    rx(64'h11);
    rx(64'h22);
    rx(64'h33);
    cyc(2);
    `CHK("intId", 16'h0001, intId)
    `CHK("irqLine", 1'b1, irqLine)
    cmd(cmf_pkg::CMD_READ_ALL, 6'h01);
    `CHK("ctrl1", 16'ha400, bufCtrl)
    `CHK("data1", 64'h11, bufData)
    `CHK("intId", 16'h0002, intId)
    cmd(cmf_pkg::CMD_READ_ALL, 6'h02);
    `CHK("ctrl2", 16'he480, bufCtrl)
    `CHK("data2", 64'h33, bufData)
    `CHK("irqLine", 1'b0, irqLine)
    cmd(8'h10, 6'h02);
    `CHK("ctrl2b", 16'h4480, bufCtrl)
    rx(64'h44);
    cmd(8'h13, 6'h01);
    `CHK("data1b", 64'h44, bufData)
  endtask
  // Status cause against pending object
  task automatic t_status();
    coreStatus = 5'h10;
    coreIsError = 1'b1;
    pulse(coreStatusUpdate);
    cyc(2);
    `CHK("gated", 16'h0001, intId)
    coreIsError = 1'b0;
    pulse(coreStatusUpdate);
    cyc(2);
    `CHK("intId", cmf_pkg::INT_ID_STATUS, intId)
    pulse(swStatusWrite);
    lineEnable = 1'b0;
    cyc(2);
    `CHK("status", 5'h00, statusOut)
    `CHK("intId", cmf_pkg::INT_ID_STATUS, intId)
    `CHK("irqLine", 1'b0, irqLine)
    lineEnable = 1'b1;
    pulse(statusRead);
    cyc(2);
    `CHK("intId", 16'h0001, intId)
    // service read clears pending at once
    cmd(8'h08, 6'h01);
    `CHK("intId", 16'h0000, intId)
  endtask
  // Remote request: cancelled by data, then answered
  task automatic t_remote();
    lag = 8'd60;
    wobj(6'h03, 29'h0abc, 16'h0100);
    `CHK("remoteId", 29'h0abc, remoteId)
    `CHK("remoteObj", 6'h03, remoteObj)
    rxId = 29'h0abc;
    rx(64'h55);
    cyc(3);
    `CHK("remoteReq", 1'b0, remoteReq)
    lag = 8'd2;
    wobj(6'h03, 29'h0abc, 16'h0100);
    waitv(0, 1'b1);
    `CHK("sentObj", 6'h03, remoteObj)
    waitv(1, 1'b0);
    // Flag clears at the edge after the pulse, the request one edge later
    `CHK("dropLag", 2, i)
  endtask
  // Bit period in clocks
  task automatic t_bits();
    quantumPrescaler = 6'h02;
    waitv(2, 1'b1);
    cyc(1);
    waitv(2, 1'b1);
    cyc(1);
    waitv(2, 1'b1);
    // Seven quanta of two clocks, less the clock stepped past the pulse
    `CHK("period", 13, i)
  endtask
  // Late edge stretches phase one by the jump width; reset restores idle level
  task automatic t_sync();
    waitv(2, 1'b1);
    cyc(2);
    busIn = 1'b0;
    waitv(2, 1'b1);
    // Seven quanta plus one quantum of jump, less the two clocks waited
    `CHK("lateEdge", 14, i)
    `CHK("sampled", 1'b0, sampledBit)
    busIn = 1'b1;
    rst = 1'b1;
    cyc(2);
    rst = 1'b0;
    `CHK("rstSample", 1'b1, sampledBit)
    `CHK("rstId", 16'h0000, intId)
  endtask
  // Main sequence
  initial
  begin
    {rst, bufValidIn, busIn, lineEnable, statusIrqEnable} = 5'h1f;
    {cmdStrobe, bufDirIn, rxStore, coreStatusUpdate, coreIsError} = 5'h00;
    // jump width one quantum, within both phases
    {swStatusWrite, statusRead, errorIrqEnable, hardSync, jumpWidth} = 5'h00;
    {cmdMask, lag, cmdObj, bufIdIn, bufCtrlIn, bufDataIn, rxData, rxId} = '0;
    {coreStatus, swStatusData, rxDlc, phaseBufferTwo} = '0;
    {quantumPrescaler, propSeg, phaseBufferOne} = {6'h01, 3'h1, 3'h2};
    {n_errors, cmp_count} = '0;
    cyc(4);
    rst = 1'b0;
    `CHK("sampled", 1'b1, sampledBit)
    t_fifo();
    t_status();
    t_remote();
    t_bits();
    t_sync();
    stop_test();
  end
endmodule
`default_nettype wire

// File: cmf_pkg.sv
// Shared constants, types and helpers for the CAN message store, interrupt and bit-timing block
`default_nettype none
package cmf_pkg;
  // Message RAM size
  localparam int MAX_OBJ = 32;
  // Command mask value that reads a whole object and clears its fresh and pending flags
  localparam logic [7:0] CMD_READ_ALL = 8'h7f;
  // Command mask field positions
  localparam int MASK_WRITE     = 7;
  localparam int MASK_ARB       = 5;
  localparam int MASK_CTRL      = 4;
  localparam int MASK_CLR_PEND  = 3;
  localparam int MASK_REQ_FRESH = 2;
  localparam int MASK_DATA_A    = 1;
  localparam int MASK_DATA_B    = 0;
  // Message control field positions
  localparam int MC_FRESH     = 15;
  localparam int MC_OVERRUN   = 14;
  localparam int MC_PEND      = 13;
  localparam int MC_RX_IE     = 10;
  localparam int MC_SEND_REQ  = 8;
  localparam int MC_BLOCK_END = 7;
  localparam int MC_DLC_MSB   = 3;
  // Status field positions
  localparam int ST_RX_DONE = 4;
  localparam int ST_TX_DONE = 3;
  localparam int ST_LEC_MSB = 2;
  // Reset values
  localparam logic [15:0] MC_RESET     = 16'h0000;
  localparam logic [4:0]  STATUS_RESET = 5'h00;
  localparam logic [63:0] DATA_RESET   = 64'h0000_0000_0000_0000;
  localparam logic [28:0] ID_RESET     = 29'h0000_0000;
  // Interrupt identifier codes
  localparam logic [15:0] INT_ID_NONE   = 16'h0000;
  localparam logic [15:0] INT_ID_STATUS = 16'h8000;
  // Bit-timing ranges, in time quanta or prescaler counts
  localparam logic [5:0] BRP_MIN = 6'h01;
  localparam logic [5:0] BRP_MAX = 6'h20;
  localparam int SYNC_TQ = 1;
  // Bit segment of the nominal bit time
  typedef enum {SEG_SYNC, SEG_ONE, SEG_TWO} cmf_seg_t;

  // Lowest set bit: {found, index}
  function automatic logic [5:0] first_set(input logic [31:0] vec);
    logic [5:0] res;
    res = 6'h00;
    for (int i = 31; i >= 0; i--)
    begin
      if (vec[i])
      begin
        res = {1'b1, 5'(i)};
      end
    end
    return res;
  endfunction
endpackage
`default_nettype wire

// File: cmf_remote_node.sv
// Far-side node model that answers remote-frame requests after a set lag
`timescale 1ns/100ps
`default_nettype none
module cmf_remote_node (
  input  wire logic       clk_sys,
  input  wire logic       rst,
  input  wire logic       remoteReq,
  input  wire logic [7:0] lag,
  output var  logic       remoteSent
);
  logic [7:0] cntQ;
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      cntQ       <= 8'h00;
      remoteSent <= 1'b0;
    end
    else if (!remoteReq || remoteSent)
    begin
      cntQ       <= 8'h00;
      remoteSent <= 1'b0;
    end
    else
    begin
      cntQ       <= cntQ + 8'h01;
      remoteSent <= (cntQ == lag);
    end
  end
endmodule
`default_nettype wire
